// >>> spx_pkg.sv
// Shared constants and types for the serial audio input stage.
// Operation
// RL1 - Accept LJ, I2S, RJ with 16/18/20/24 bits.
// RL2 - Capture data and frame clock on rising bit clock.
// RL3 - Right-justified: frame clock high means left.
// RL4 - Right-justified MSB 12 or 16 clocks late.
// RL5 - I2S is default; frame clock low means left.
// RL6 - I2S MSB one bit clock after transition.
// RL7 - Left-justified: high is left, MSB undelayed.
// RL8 - Biphase clock divided from oversampling clock.
// RL9 - Divider supports 384 and 256 frame ratios.
// RL10 - Static config; hand pairs once per frame.
package spx_pkg;

  // Sample and slot geometry.
  localparam int SAMPLE_W  = 24;
  localparam int CNT_W     = 6;
  localparam int WID_W     = 5;
  localparam logic [CNT_W-1:0] SLOT_BITS = 6'h20;
  localparam logic [CNT_W-1:0] CNT_MAX   = 6'h3f;
  localparam logic [CNT_W-1:0] I2S_DELAY = 6'h01;
  localparam logic [CNT_W-1:0] LJ_DELAY  = 6'h00;

  // Word widths in bits, selected by the width code.
  localparam logic [WID_W-1:0] W16 = 5'h10;
  localparam logic [WID_W-1:0] W18 = 5'h12;
  localparam logic [WID_W-1:0] W20 = 5'h14;
  localparam logic [WID_W-1:0] W24 = 5'h18;

  // Oversampling clock edges per biphase tick.
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_256 = 2'h2;
  localparam logic [DIV_W-1:0] DIV_384 = 2'h3;

  // Register byte offsets.
  localparam int AW = 4;
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_STAT = 4'h4;
  localparam logic [AW-1:0] ADDR_FRM  = 4'h8;

  // Control register fields and reset value.
  localparam int CTRL_W       = 6;
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_WID_LSB = 2;
  localparam int CTRL_R384    = 4;
  localparam int CTRL_EN      = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h2c;

  // Status register fields.
  localparam int STAT_OVR  = 0;
  localparam int STAT_PEND = 1;
  localparam int STAT_HAVE = 2;
  localparam int STAT_LVL  = 4;
  localparam int FRM_W     = 16;

  // Framing formats; code 3 of the field falls back to I2S.
  typedef enum logic [1:0] {FMT_I2S, FMT_LJ, FMT_RJ} spx_fmt_t;

endpackage

// >>> spx_stream_if.sv
// Valid/ready stream carrier between the stage's own modules.
`timescale 1ns/1ps
`default_nettype none
interface spx_stream_if #(parameter int W = 8) ();
  logic         valid;  // Word offered.
  logic         ready;  // Word accepted.
  logic [W-1:0] data;   // Word contents.
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> spx_fifo.sv
// Small synchronous FIFO between sample capture and the encoder.
`timescale 1ns/1ps
`default_nettype none
module spx_fifo #(
  parameter int W     = 48,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Streams.
  spx_stream_if.snk         in_s,
  spx_stream_if.src         out_s,
  // Fill level.
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  // Refuse depths the pointer wrap cannot serve.
  if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1) begin : g_chk
    $error("spx_fifo needs a power-of-two depth of at least 2.");
  end

  // All state of the FIFO.
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } spx_fifo_st_t;

  spx_fifo_st_t q, d;
  logic push, pop;

  // Full and empty follow the count exactly.
  assign in_s.ready  = (q.cnt != (PW+1)'(DEPTH));
  assign out_s.valid = (q.cnt != '0);
  assign out_s.data  = q.mem[q.rp];
  assign level       = q.cnt;
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  // Next state: write at the tail, read from the head.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_s.data;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// >>> spx_div.sv
// Divider that turns the oversampling clock into biphase ticks.
`timescale 1ns/1ps
`default_nettype none
module spx_div
  import spx_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Oversampling clock level and ratio select.
  input  wire logic osc,
  input  wire logic r384,
  // One-cycle biphase tick.
  output logic      tick
);
  // All state of the divider.
  typedef struct packed {
    logic             osc;
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } spx_div_st_t;

  spx_div_st_t q, d;
  logic             rise;
  logic [DIV_W-1:0] div;

  assign rise = osc & ~q.osc;
  assign div  = r384 ? DIV_384 : DIV_256;  // [RL9]
  assign tick = q.tick;

  // Count oversampling edges and tick every div of them.
  always_comb begin
    d = q;
    d.osc = osc;
    d.tick = 1'b0;
    if (rise) begin
      if (q.cnt >= div - 1'b1) begin
        d.cnt = '0;
        d.tick = 1'b1;  // [RL8]
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Helper count of oversampling edges since the last tick.
  logic [DIV_W:0] hc_q;
  logic           hr_q;  // Ratio in force when the count restarted.

  // A ratio change between two ticks makes that one spacing irregular.
  always_ff @(posedge clk) begin
    if (rst || q.tick) begin
      hr_q <= r384;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || q.tick) begin
      hc_q <= '0;
    end else if (rise) begin
      hc_q <= hc_q + 1'b1;
    end
  end

  tick_ratio_a: assert property (@(posedge clk) disable iff (rst) // [RL9]
    (q.tick && r384 == hr_q && hc_q != '0) |-> hc_q == {1'b0, div})
    else $error("Biphase tick spacing differs from ratio.");
  tick_cause_a: assert property (@(posedge clk) disable iff (rst) // [RL8]
    q.tick |-> $past(rise))
    else $error("Biphase tick without oversampling edge.");

endmodule
`default_nettype wire

// >>> spx_rx.sv
// Serial audio input stage of the biphase transmitter, with bus slave.
`timescale 1ns/1ps
`default_nettype none
module spx_rx
  import spx_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst,
  // Avalon-MM register slave.
  input  wire logic [AW-1:0]       avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // Serial audio source.
  input  wire logic                bit_clock,
  input  wire logic                frame_clock,
  input  wire logic                serial_data,
  // Oversampling clock and biphase tick.
  input  wire logic                oversampling_clock,
  output logic                     biphase_tick,
  // Sample pairs to the biphase encoder.
  output logic                     enc_valid,
  input  wire logic                enc_ready,
  output logic [SAMPLE_W-1:0]      enc_left,
  output logic [SAMPLE_W-1:0]      enc_right
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // The level field must fit in the status word.
  if (LW > 32 - STAT_LVL) begin : g_chk
    $error("spx_rx FIFO depth too large for the status word.");
  end

  ////////////////////////////////////////////////////////////////////
  // State.
  ////////////////////////////////////////////////////////////////////

  // All state of the stage in one record.
  typedef struct packed {
    logic [CTRL_W-1:0]     ctrl;   // Format, width, ratio, enable.
    logic                  ovr;    // Sticky pair overrun.
    logic                  sclk;   // Bit clock one cycle ago.
    logic                  lr;     // Frame clock at last bit edge.
    logic [CNT_W-1:0]      cnt;    // Bit edges since slot start.
    logic                  slot_l; // Current slot is left.
    logic [SAMPLE_W-1:0]   sh;     // Shift register.
    logic [SAMPLE_W-1:0]   left;   // Finished left word.
    logic                  have_l; // Left word waits for right.
    logic                  pend;   // Pair waits for FIFO room.
    logic [2*SAMPLE_W-1:0] pair;   // Pair on offer.
    logic [FRM_W-1:0]      frames; // Pairs handed on.
    logic                  ack;    // Bus answer phase.
    logic [31:0]           rdata;  // Read data register.
  } spx_st_t;

  spx_st_t q, d;

  // Stream from capture into the FIFO, and out to the encoder.
  spx_stream_if #(.W(2*SAMPLE_W)) fin ();
  spx_stream_if #(.W(2*SAMPLE_W)) fout ();
  logic [LW-1:0] level;

  ////////////////////////////////////////////////////////////////////
  // Configuration decode.
  ////////////////////////////////////////////////////////////////////

  logic [1:0]        fmt_code;  // Raw format field.
  spx_fmt_t          fmt;       // Decoded format.
  logic [WID_W-1:0]  w;         // Word width in bits.
  logic [CNT_W-1:0]  start;     // Bit index of the MSB.
  logic              en;        // Capture enable.

  assign fmt_code = q.ctrl[CTRL_FMT_LSB +: 2];
  assign en       = q.ctrl[CTRL_EN];

  // The unused code falls back to the default I2S framing.
  assign fmt = (fmt_code == 2'h3) ? FMT_I2S : spx_fmt_t'(fmt_code);

  // Width code to bit count.
  always_comb begin
    unique case (q.ctrl[CTRL_WID_LSB +: 2])
      2'h0: w = W16;  // [RL1]
      2'h1: w = W18;
      2'h2: w = W20;
      2'h3: w = W24;
    endcase
  end

  // MSB position within the slot for each framing.
  always_comb begin
    unique case (fmt)
      FMT_I2S: start = I2S_DELAY;  // [RL6]
      FMT_LJ:  start = LJ_DELAY;   // [RL7]
      FMT_RJ:  start = SLOT_BITS - CNT_W'(w);  // [RL4]
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Bit edge, slot position and word window.
  ////////////////////////////////////////////////////////////////////

  logic                rise;    // Rising bit clock seen.
  logic                trans;   // Frame clock changed at this edge.
  logic [CNT_W-1:0]    pos;     // Bit index at this edge.
  logic                in_win;  // This bit belongs to the word.
  logic                done;    // This bit is the LSB.
  logic                new_l;   // Slot polarity at a transition.
  logic [SAMPLE_W-1:0] shn;     // Shift register after this bit.
  logic [SAMPLE_W-1:0] word;    // MSB-aligned finished word.

  // Inputs are synchronous; both lines are taken at the rising edge.
  assign rise  = bit_clock & ~q.sclk;  // [RL2]
  assign trans = frame_clock != q.lr;

  // The position restarts at every frame clock transition.
  assign pos = trans ? '0 : ((q.cnt == CNT_MAX) ? CNT_MAX : q.cnt + 1'b1);

  assign in_win = (pos >= start) && (pos < start + CNT_W'(w));
  assign done   = pos == start + CNT_W'(w) - 1'b1;

  // I2S puts left in the low phase; the other two in the high phase.
  assign new_l = (fmt == FMT_I2S) ? ~frame_clock : frame_clock;  // [RL3] [RL5]

  assign shn  = {q.sh[SAMPLE_W-2:0], serial_data};
  assign word = shn << (WID_W'(SAMPLE_W) - w);

  ////////////////////////////////////////////////////////////////////
  // Bus slave helpers.
  ////////////////////////////////////////////////////////////////////

  logic             req;    // A bus request is up.
  logic             wr_go;  // Write takes effect now.
  logic [31:0]      stat;   // Status word.
  logic             ovr_new;  // Overrun raised at this edge.

  assign req   = avs_read | avs_write;
  assign wr_go = avs_write & q.ack;

  // One wait cycle, then the answer.
  assign avs_waitrequest = req & ~q.ack;
  assign avs_readdata    = q.rdata;

  always_comb begin
    stat = '0;
    stat[STAT_OVR]  = q.ovr;
    stat[STAT_PEND] = q.pend;
    stat[STAT_HAVE] = q.have_l;
    stat[STAT_LVL +: LW] = level;
  end

  ////////////////////////////////////////////////////////////////////
  // Next state.
  ////////////////////////////////////////////////////////////////////

  always_comb begin
    d = q;
    d.sclk = bit_clock;
    ovr_new = 1'b0;

    // The FIFO took the pending pair.
    if (q.pend && fin.ready) begin
      d.pend = 1'b0;
    end

    // Capture runs only while enabled; disabling drops a half frame.
    if (!en) begin
      d.cnt    = '0;
      d.have_l = 1'b0;
    end else if (rise) begin
      d.lr  = frame_clock;  // [RL2]
      d.cnt = pos;
      if (trans) begin
        d.slot_l = new_l;
      end
      if (in_win) begin
        d.sh = shn;
      end
      if (done) begin
        if (trans ? new_l : q.slot_l) begin
          d.left   = word;
          d.have_l = 1'b1;
        end else if (q.have_l) begin
          // A full pair; it waits if the FIFO is full, unless a pair already waits, when it is lost.
          d.have_l = 1'b0;
          if (q.pend && !fin.ready) begin
            d.ovr = 1'b1;
            ovr_new = 1'b1;  // Remembered so a clear in this cycle cannot undo it.
          end else begin
            d.pend   = 1'b1;  // [RL10]
            d.pair   = {q.left, word};
            d.frames = q.frames + 1'b1;
          end
        end
      end
    end

    // Bus answer phase and read data.
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      unique case (avs_address)
        ADDR_CTRL: d.rdata = 32'(q.ctrl);
        ADDR_STAT: d.rdata = stat;
        ADDR_FRM:  d.rdata = 32'(q.frames);
        default:   d.rdata = '0;
      endcase
    end

    // Register writes; a new overrun wins over the clear.
    if (wr_go && avs_byteenable[0]) begin
      if (avs_address == ADDR_CTRL) begin
        d.ctrl = avs_writedata[CTRL_W-1:0];  // [RL10]
      end
      if (avs_address == ADDR_STAT && avs_writedata[STAT_OVR] && !ovr_new) begin
        d.ovr = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q      <= '0;
      q.ctrl <= CTRL_RST;  // [RL5]
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // FIFO and divider.
  ////////////////////////////////////////////////////////////////////

  assign fin.valid  = q.pend;
  assign fin.data   = q.pair;
  assign fout.ready = enc_ready;
  assign enc_valid  = fout.valid;
  assign enc_left   = fout.data[2*SAMPLE_W-1:SAMPLE_W];
  assign enc_right  = fout.data[SAMPLE_W-1:0];

  spx_fifo #(.W(2*SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rst   (rst),
    .in_s  (fin),
    .out_s (fout),
    .level (level)
  );

  // Biphase ticks from the oversampling clock.
  spx_div u_div (
    .clk  (clk),
    .rst  (rst),
    .osc  (oversampling_clock),
    .r384 (q.ctrl[CTRL_R384]),  // [RL9]
    .tick (biphase_tick)        // [RL8]
  );

  ////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_edge_trans;
    rise && trans && en;
  endsequence

  width_legal_a: assert property ( // [RL1]
    w == W16 || w == W18 || w == W20 || w == W24)
    else $error("Word width outside the supported set.");

  edge_only_a: assert property ( // [RL2]
    (en && q.sh != $past(q.sh)) |-> $past(rise))
    else $error("Data taken away from a rising bit clock.");

  rj_polarity_a: assert property ( // [RL3]
    (s_edge_trans and fmt == FMT_RJ) |=> q.slot_l == q.lr)
    else $error("Right-justified slot polarity wrong.");

  rj_msb20_a: assert property ( // [RL4]
    (fmt == FMT_RJ && w == W20) |-> start == 6'h0c)
    else $error("Right-justified 20-bit MSB delay wrong.");

  rj_msb16_a: assert property ( // [RL4]
    (fmt == FMT_RJ && w == W16) |-> start == 6'h10)
    else $error("Right-justified 16-bit MSB delay wrong.");

  i2s_default_a: assert property ( // [RL5]
    $fell(rst) |-> fmt == FMT_I2S)
    else $error("Framing after reset is not I2S.");

  i2s_polarity_a: assert property ( // [RL5]
    (s_edge_trans and fmt == FMT_I2S) |=> q.slot_l == !q.lr)
    else $error("I2S slot polarity wrong.");

  i2s_delay_a: assert property ( // [RL6]
    (s_edge_trans and fmt == FMT_I2S) |-> !in_win ##1 (!rise)[*3])
    else $error("I2S MSB taken at the transition.");

  lj_msb_a: assert property ( // [RL7]
    (s_edge_trans and fmt == FMT_LJ) |-> in_win && start == LJ_DELAY)
    else $error("Left-justified MSB not taken at the transition.");

  pair_once_a: assert property ( // [RL10]
    $rose(q.pend) |-> q.frames == $past(q.frames) + 1'b1 && !q.have_l)
    else $error("Pair handed on without a finished frame.");

  sequence s_right_lsb;
    rise && en && done && !(trans ? new_l : q.slot_l) && q.have_l;
  endsequence

  pair_offer_a: assert property ( // [RL10]
    s_right_lsb |=> q.pend || q.ovr)
    else $error("Finished pair neither offered nor flagged.");

  ovr_wins_a: assert property ( // [RL10]
    (s_right_lsb and q.pend && !fin.ready) |=> q.ovr)
    else $error("Lost pair did not raise the overrun flag.");

  pend_hold_a: assert property ( // [RL10]
    (q.pend && !fin.ready) |=> q.pend && $stable(q.pair))
    else $error("Pending pair changed before the buffer took it.");

  enc_hold_a: assert property ( // [RL10]
    (enc_valid && !enc_ready) |=> enc_valid && $stable(enc_left) && $stable(enc_right))
    else $error("Offered pair changed before the encoder took it.");

  rj_lsb_a: assert property ( // [RL4]
    (fmt == FMT_RJ && rise && en && done) |-> pos == SLOT_BITS - 1'b1)
    else $error("Right-justified LSB not at the slot end.");

  word_align_a: assert property ( // [RL1]
    (rise && en && done) |-> (word << w) == '0)
    else $error("Word bits below the sample are not zero.");

endmodule
`default_nettype wire

// >>> spx_src_model.sv
// Behavioural serial audio source and oversampling clock for the input stage.
`timescale 1ns/1ps
`default_nettype none
module spx_src_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Serial audio lines and oversampling clock.
  output logic      bit_clock,
  output logic      frame_clock,
  output logic      serial_data,
  output logic      oversampling_clock
);
  ////////////////////////////////////////
  // Lines start quiet so the stage never sees unknowns.
  initial begin
    bit_clock          = 1'b0;
    frame_clock        = 1'b1;
    serial_data        = 1'b0;
    oversampling_clock = 1'b0;
  end

  // Oversampling clock rises once every two cycles and runs free.
  always @(posedge clk) begin
    oversampling_clock <= rst ? 1'b0 : ~oversampling_clock;
  end

  ////////////////////////////////////////
  // One bit: lines change on the fall, then two cycles low and two high.
  task automatic bit_out(input logic f, input logic d);
    @(posedge clk);
    bit_clock   <= 1'b0;
    frame_clock <= f;
    serial_data <= d;
    repeat (2) @(posedge clk);
    bit_clock <= 1'b1;
    @(posedge clk);
  endtask

  // One frame, after a lead-in bit at the right-slot level; unused slots carry noise.
  task automatic send(input logic [1:0] fmt, input int w, input logic [23:0] l,
                      input logic [23:0] r);
    logic        lv;
    int          ms;
    logic [23:0] v;
    lv = (fmt == 2'h1) || (fmt == 2'h2);
    ms = (fmt == 2'h2) ? 32 - w : ((fmt == 2'h1) ? 0 : 1);
    bit_out(~lv, 1'($urandom));
    for (int s = 0; s < 2; s++) begin
      v = (s == 0) ? l : r;
      for (int p = 0; p < 32; p++) begin
        bit_out((s == 0) ? lv : ~lv, (p >= ms && p < ms + w) ? v[ms + w - 1 - p] : 1'($urandom));
      end
    end
    // A released data line shows the inverse of its last value.
    @(posedge clk);
    serial_data <= ~serial_data;
  endtask
endmodule
`default_nettype wire

// >>> spx_rx_test.sv
// Self-checking bench for the serial audio input stage.
`timescale 1ns/1ps
`default_nettype none
module spx_rx_test
  import spx_pkg::*;
;
  logic                clk;
  logic                rst;
  logic [AW-1:0]       avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                bit_clock;
  logic                frame_clock;
  logic                serial_data;
  logic                oversampling_clock;
  logic                biphase_tick;
  logic                enc_valid;
  logic                enc_ready;
  logic                stall;
  logic [SAMPLE_W-1:0] enc_left;
  logic [SAMPLE_W-1:0] enc_right;
  logic [47:0]         exp_q[$];
  logic [31:0]         q;
  int                  n;
  int                  bad_count;
  int                  total_checks;

  ////////////////////////////////////////
  // Clock of 4 ns period.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  spx_rx #(.FIFO_DEPTH(4)) i_dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_clock(bit_clock),
    .frame_clock(frame_clock), .serial_data(serial_data),
    .oversampling_clock(oversampling_clock), .biphase_tick(biphase_tick),
    .enc_valid(enc_valid), .enc_ready(enc_ready), .enc_left(enc_left), .enc_right(enc_right));

  spx_src_model i_src (
    .clk(clk), .rst(rst), .bit_clock(bit_clock), .frame_clock(frame_clock),
    .serial_data(serial_data), .oversampling_clock(oversampling_clock));

  ////////////////////////////////////////
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One bus cycle, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rq);
    int i;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rq = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      bad_count++;
      final_report();
    end
  endtask

  // Counts edges up to the next biphase tick.
  task automatic wait_tick(output int cnt);
    for (cnt = 1; cnt < 40; cnt++) begin
      @(posedge clk);
      if (biphase_tick === 1'b1) break;
    end
    if (cnt == 40) begin
      bad_count++;
      final_report();
    end
  endtask

  // Sends one frame of random samples and notes the aligned pair when it must arrive.
  task automatic frame(input logic [1:0] fmt, input logic [1:0] wc, input logic keep);
    int          w;
    logic [23:0] l;
    logic [23:0] r;
    w = (wc == 2'h3) ? 24 : 16 + 2 * int'(wc);
    l = 24'($urandom) & ~(24'hffffff << w);
    r = 24'($urandom) & ~(24'hffffff << w);
    if (keep) exp_q.push_back({l << (24 - w), r << (24 - w)});
    i_src.send(fmt, w, l, r);
  endtask

  // Waits until every noted pair has been taken.
  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge clk);
    if (exp_q.size() > 0) begin
      bad_count++;
      final_report();
    end
  endtask

  ////////////////////////////////////////
  // Encoder side accepts at random unless stalled.
  always @(posedge clk) begin
    enc_ready <= ~stall & 1'($urandom);
  end

  // Each accepted pair is matched against the oldest note.
  always @(posedge clk) begin
    logic [47:0] e;
    if (rst === 1'b0 && enc_valid === 1'b1 && enc_ready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      check(enc_left, e[47:24]);
      check(enc_right, e[23:0]);
    end
  end

  ////////////////////////////////////////
  // Main sequence: registers, all formats and widths, divider, overrun.
  initial begin
    rst            = 1'b1;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = '0;
    stall          = 1'b0;
    bad_count      = 0;
    total_checks   = 0;
    void'($urandom(32'h961d68c8));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, ADDR_CTRL, 32'h0, 4'hf, q);
    check(q, 32'h2c);
    bus(1'b1, 4'hc, 32'h0, 4'hf, q);
    bus(1'b1, ADDR_CTRL, 32'h0, 4'h0, q);
    bus(1'b0, 4'hc, 32'h0, 4'hf, q);
    check(q, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0, 4'hf, q);
    check(q, 32'h2c);
    // Every format code, code 3 included, with every width.
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 4; c++) begin
        bus(1'b1, ADDR_CTRL, 32'h20 | 32'(c << 2) | 32'(f), 4'h1, q);
        frame(2'(f), 2'(c), 1'b1);
      end
    end
    drain();
    // Tick spacing for both ratios, after the divider settles.
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, ADDR_CTRL, 32'h2c | 32'(r << 4), 4'h1, q);
      repeat (3) wait_tick(n);
      check(32'(n), (r == 1) ? 32'h6 : 32'h4);
    end
    // Capture disabled: a whole frame must leave no pair and no state behind.
    bus(1'b1, ADDR_CTRL, 32'h01, 4'h1, q);
    frame(2'h1, 2'h3, 1'b0);
    bus(1'b0, ADDR_STAT, 32'h0, 4'hf, q);
    check(q, 32'h0);
    // Encoder stalls: four pairs fill the buffer, one pends, the sixth is lost.
    stall <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h2d, 4'h1, q);
    for (int k = 0; k < 6; k++) frame(2'h1, 2'h3, k < 5);
    bus(1'b0, ADDR_STAT, 32'h0, 4'hf, q);
    check(q, 32'h43);
    bus(1'b1, ADDR_STAT, 32'h1, 4'h1, q);
    bus(1'b0, ADDR_STAT, 32'h0, 4'hf, q);
    check(q, 32'h42);
    stall <= 1'b0;
    drain();
    bus(1'b0, ADDR_STAT, 32'h0, 4'hf, q);
    check(q, 32'h0);
    // Sixteen pairs from the format sweep and five from the stall; the lost one is not counted.
    bus(1'b0, ADDR_FRM, 32'h0, 4'hf, q);
    check(q, 32'h15);
    final_report();
  end
endmodule
`default_nettype wire
